//--- pkg/fe_seq_cfg.svh
// Register offsets, field positions, command layout, queue size and reset values for the front-end sequencer
`ifndef FE_SEQ_CFG_SVH
`define FE_SEQ_CFG_SVH

// Base of the front-end map, upper 24 address bits
`define FE_BASE_HI 24'h400800

// Word indexes (address bits 7:2)
`define IDX_CTRL 6'h00
`define IDX_PUSH 6'h01
`define IDX_TIMEOUT 6'h02
`define IDX_STATUS 6'h03
`define IDX_FLAGS 6'h04
`define IDX_MASK 6'h05
`define IDX_RES0 6'h06
`define IDX_CFG 6'h0B
`define NUM_RES 5

// Control fields
`define CTRL_RUN 0
`define CTRL_PAUSE 1

// Flag and mask fields
`define FLG_COMPLETE 0
`define FLG_TDONE 1
`define FLG_TFAULT 2
`define FLG_QOVF 3
`define FLG_W 4

// Command layout
`define CMD_MSB 31
`define CMD_TMR_SEL 30
`define CMD_ADDR_HI 30
`define CMD_ADDR_LO 25
`define CMD_DATA_W 25
`define CMD_TIME_W 30

// Command queue
`define QUEUE_DEPTH 8
`define QUEUE_AW 3

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_ERROR 2'h1

// Reset values
`define CFG_RESET 25'h0000000
`define MASK_RESET 4'h0

`endif

//--- pkg/fe_seq_pkg.sv
// Types shared by the front-end sequencer
package fe_seq_pkg;
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_FETCH,
		SEQ_WAIT
	} seq_state_e;
endpackage

//--- hw/frontend_sequencer_reg_access.sv
// Register access front end and command sequencer of the measurement front end
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "fe_seq_cfg.svh"

module frontend_sequencer_reg_access (
	// Clock, reset, enable
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic CE,
	// Front-end clock tick, one cycle per front-end period
	input wire logic FE_TICK,
	// Register port
	input wire logic [31:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	output logic [1:0] RESP,
	// Result loads from the measurement blocks
	input wire logic [`NUM_RES-1:0] RES_LOAD,
	input wire logic [`CMD_DATA_W-1:0] RES_DATA,
	// Configuration driven to the analog side
	output logic [`CMD_DATA_W-1:0] CFG_OUT,
	// Interrupt, DMA requests, clock gate
	output logic IRQ,
	output logic CMD_DMA_REQ,
	output logic RES_DMA_REQ,
	output logic SEQ_CLK_EN
);
	logic run_q;
	logic pause_q;
	logic [`FLG_W-1:0] flags_q;
	logic [`FLG_W-1:0] mask_q;
	logic [`CMD_DATA_W-1:0] cfg_q;
	logic [`CMD_DATA_W-1:0] res_q [`NUM_RES];
	logic [31:0] queue_q [`QUEUE_DEPTH];
	logic [`QUEUE_AW-1:0] wr_ptr_q;
	logic [`QUEUE_AW-1:0] rd_ptr_q;
	logic [`QUEUE_AW:0] count_q;
	logic [`CMD_TIME_W-1:0] wait_q;
	logic [`CMD_TIME_W-1:0] tout_q;
	logic [31:0] rdata_q;
	logic [1:0] resp_q;
	logic res_dma_q;
	fe_seq_pkg::seq_state_e state_q;

	// Host decode
	logic host_hit;
	logic [5:0] hidx;
	logic known;
	logic read_only;
	logic exempt;
	logic is_result;
	logic host_ok;
	logic host_err;

	assign host_hit = (ADDR[31:8] == `FE_BASE_HI);
	assign hidx = ADDR[7:2];

	function automatic logic idx_known(input logic [5:0] i);
		idx_known = (i <= `IDX_MASK) || (i == `IDX_CFG) ||
			(i >= `IDX_RES0 && i < `IDX_RES0 + 6'(`NUM_RES));
	endfunction

	function automatic logic idx_ro(input logic [5:0] i);
		idx_ro = (i == `IDX_TIMEOUT) || (i == `IDX_STATUS);
	endfunction

	assign known = host_hit && idx_known(hidx);
	assign read_only = idx_ro(hidx);
	assign exempt = (hidx == `IDX_PUSH) || (hidx == `IDX_CTRL) || (hidx == `IDX_FLAGS) || (hidx == `IDX_MASK);
	assign is_result = (hidx >= `IDX_RES0) && (hidx < `IDX_RES0 + 6'(`NUM_RES));

	// Blocked writes, read-only writes and result writes while running all error
	assign host_ok = WR && known && !read_only && (!run_q || exempt);
	assign host_err = WR && !host_ok;

	// Sequencer decode
	logic pop;
	logic [31:0] cmd;
	logic seq_we;
	logic [5:0] sidx;
	logic [`CMD_DATA_W-1:0] sdata;
	logic seq_ok;
	logic tick;

	assign tick = FE_TICK && !pause_q;
	assign cmd = queue_q[rd_ptr_q];
	assign pop = (state_q == fe_seq_pkg::SEQ_FETCH) && run_q && tick && (count_q != '0);
	assign seq_we = pop && cmd[`CMD_MSB];
	assign sidx = cmd[`CMD_ADDR_HI:`CMD_ADDR_LO];
	assign sdata = cmd[`CMD_DATA_W-1:0];
	// Read-only, push and flag targets are dropped with no error
	assign seq_ok = seq_we && idx_known(sidx) && !idx_ro(sidx) &&
		(sidx != `IDX_PUSH) && (sidx != `IDX_FLAGS);

	logic host_wr_ctrl;
	logic seq_wr_ctrl;
	logic host_stop;
	logic seq_stop;

	assign host_wr_ctrl = host_ok && (hidx == `IDX_CTRL);
	assign seq_wr_ctrl = seq_ok && (sidx == `IDX_CTRL);
	assign host_stop = host_wr_ctrl && !WDATA[`CTRL_RUN];
	assign seq_stop = seq_wr_ctrl && !sdata[`CTRL_RUN];

	// Control register; only the host can start the sequencer
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			run_q <= 1'b0;
			pause_q <= 1'b0;
		end
		else if (CE)
		begin
			if (host_wr_ctrl)
			begin
				run_q <= WDATA[`CTRL_RUN];
				pause_q <= WDATA[`CTRL_PAUSE];
			end
			else if (seq_wr_ctrl)
			begin
				run_q <= run_q && sdata[`CTRL_RUN];
				pause_q <= sdata[`CTRL_PAUSE];
			end
		end
	end

	// Command queue
	logic push;
	logic qfull;

	assign qfull = (count_q == 4'(`QUEUE_DEPTH));
	assign push = host_ok && (hidx == `IDX_PUSH) && !qfull;

	always_ff @(posedge CLOCK)
	begin
		if (CE && push)
		begin
			queue_q[wr_ptr_q] <= WDATA;
		end
	end

	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else if (CE)
		begin
			if (push)
			begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop)
			begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			if (push && !pop)
			begin
				count_q <= count_q + 1'b1;
			end
			else if (pop && !push)
			begin
				count_q <= count_q - 1'b1;
			end
		end
	end

	// Sequencer state and wait counter
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			state_q <= fe_seq_pkg::SEQ_IDLE;
			wait_q <= '0;
		end
		else if (CE)
		begin
			if (host_stop || !run_q)
			begin
				state_q <= run_q && !host_stop ? fe_seq_pkg::SEQ_FETCH : fe_seq_pkg::SEQ_IDLE;
				wait_q <= '0;
			end
			else
			begin
				case (state_q)
					fe_seq_pkg::SEQ_IDLE:
					begin
						state_q <= fe_seq_pkg::SEQ_FETCH;
					end
					fe_seq_pkg::SEQ_FETCH:
					begin
						if (seq_stop)
						begin
							state_q <= fe_seq_pkg::SEQ_IDLE;
						end
						else if (pop && !cmd[`CMD_MSB] && !cmd[`CMD_TMR_SEL] &&
							cmd[`CMD_TIME_W-1:0] != '0)
						begin
							wait_q <= cmd[`CMD_TIME_W-1:0];
							state_q <= fe_seq_pkg::SEQ_WAIT;
						end
					end
					fe_seq_pkg::SEQ_WAIT:
					begin
						if (tick)
						begin
							wait_q <= wait_q - 1'b1;
							if (wait_q == 30'h00000001)
							begin
								state_q <= fe_seq_pkg::SEQ_FETCH;
							end
						end
					end
					default:
					begin
						state_q <= fe_seq_pkg::SEQ_IDLE;
					end
				endcase
			end
		end
	end

	// Timeout counter, reset only by a host stop
	logic tout_load;
	logic tout_expire;

	assign tout_load = pop && !cmd[`CMD_MSB] && cmd[`CMD_TMR_SEL];
	assign tout_expire = tick && (tout_q == 30'h00000001) && !tout_load && !host_stop;

	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			tout_q <= '0;
		end
		else if (CE)
		begin
			if (host_stop)
			begin
				tout_q <= '0;
			end
			else if (tout_load)
			begin
				tout_q <= cmd[`CMD_TIME_W-1:0];
			end
			else if (tick && tout_q != '0)
			begin
				tout_q <= tout_q - 1'b1;
			end
		end
	end

	// Interrupt flags, write one to clear, set wins
	logic [`FLG_W-1:0] flag_set;
	logic [`FLG_W-1:0] flag_clr;

	always_comb
	begin
		flag_set = '0;
		flag_set[`FLG_COMPLETE] = seq_stop && run_q;
		flag_set[`FLG_TDONE] = tout_expire;
		flag_set[`FLG_TFAULT] = tout_expire && !flags_q[`FLG_COMPLETE] && !flag_set[`FLG_COMPLETE];
		flag_set[`FLG_QOVF] = host_ok && (hidx == `IDX_PUSH) && qfull;
	end

	assign flag_clr = (host_ok && hidx == `IDX_FLAGS) ? WDATA[`FLG_W-1:0] : '0;

	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			flags_q <= '0;
		end
		else if (CE)
		begin
			flags_q <= (flags_q & ~flag_clr) | flag_set;
		end
	end

	// Mask and configuration registers, host takes priority
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			mask_q <= `MASK_RESET;
			cfg_q <= `CFG_RESET;
		end
		else if (CE)
		begin
			if (host_ok && hidx == `IDX_MASK)
			begin
				mask_q <= WDATA[`FLG_W-1:0];
			end
			else if (seq_ok && sidx == `IDX_MASK)
			begin
				mask_q <= sdata[`FLG_W-1:0];
			end
			if (host_ok && hidx == `IDX_CFG)
			begin
				cfg_q <= WDATA[`CMD_DATA_W-1:0];
			end
			else if (seq_ok && sidx == `IDX_CFG)
			begin
				cfg_q <= sdata;
			end
		end
	end

	// Result registers, loaded by the measurement blocks or written
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_RES; gi++)
		begin : g_res
			always_ff @(posedge CLOCK)
			begin
				if (RST)
				begin
					res_q[gi] <= '0;
				end
				else if (CE)
				begin
					if (RES_LOAD[gi])
					begin
						res_q[gi] <= RES_DATA;
					end
					else if (host_ok && hidx == `IDX_RES0 + 6'(gi))
					begin
						res_q[gi] <= WDATA[`CMD_DATA_W-1:0];
					end
					else if (seq_ok && sidx == `IDX_RES0 + 6'(gi))
					begin
						res_q[gi] <= sdata;
					end
				end
			end
		end
	endgenerate

	// Result DMA request: set on a load of result 0 only, cleared by reading result 0
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			res_dma_q <= 1'b0;
		end
		else if (CE)
		begin
			if (RES_LOAD[0])
			begin
				res_dma_q <= 1'b1;
			end
			else if (RD && known && hidx == `IDX_RES0)
			begin
				res_dma_q <= 1'b0;
			end
		end
	end

	// Read mux
	logic [31:0] rmux;

	always_comb
	begin
		rmux = '0;
		if (known)
		begin
			if (hidx == `IDX_CTRL)
			begin
				rmux[`CTRL_RUN] = run_q;
				rmux[`CTRL_PAUSE] = pause_q;
			end
			else if (hidx == `IDX_TIMEOUT)
			begin
				rmux[`CMD_TIME_W-1:0] = tout_q;
			end
			else if (hidx == `IDX_STATUS)
			begin
				rmux[0] = (state_q == fe_seq_pkg::SEQ_WAIT);
				rmux[1] = (count_q == '0);
				rmux[2] = qfull;
				rmux[7:4] = count_q;
			end
			else if (hidx == `IDX_FLAGS)
			begin
				rmux[`FLG_W-1:0] = flags_q;
			end
			else if (hidx == `IDX_MASK)
			begin
				rmux[`FLG_W-1:0] = mask_q;
			end
			else if (hidx == `IDX_CFG)
			begin
				rmux[`CMD_DATA_W-1:0] = cfg_q;
			end
			else if (is_result)
			begin
				rmux[`CMD_DATA_W-1:0] = res_q[3'(hidx - `IDX_RES0)];
			end
		end
	end

	// Read data and response stand one cycle after the strobe
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			rdata_q <= '0;
			resp_q <= `RESP_OKAY;
		end
		else if (CE)
		begin
			rdata_q <= RD ? rmux : '0;
			resp_q <= ((RD && !known) || host_err) ? `RESP_ERROR : `RESP_OKAY;
		end
	end

	assign RDATA = rdata_q;
	assign RESP = resp_q;
	assign CFG_OUT = cfg_q;
	assign IRQ = |(flags_q & mask_q);
	assign CMD_DMA_REQ = run_q && !qfull;
	assign RES_DMA_REQ = res_dma_q;
	assign SEQ_CLK_EN = run_q && !pause_q && (state_q != fe_seq_pkg::SEQ_IDLE);
endmodule

//--- tb/fe_seq_checker.sv
// Assertions on the register port and status outputs
`timescale 1ns/1ps
`include "fe_seq_cfg.svh"
module fe_seq_checker (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic CE,
	// Register port
	input wire logic [31:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	input wire logic [1:0] RESP,
	// Status
	input wire logic [`NUM_RES-1:0] RES_LOAD,
	input wire logic RES_DMA_REQ,
	input wire logic SEQ_CLK_EN
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	wire hit = ADDR[31:8] == `FE_BASE_HI;
	wire [5:0] idx = ADDR[7:2];
	wire wr_at = CE && WR && hit;
	a_unmapped_read: assert property (CE && RD && !hit |=> RDATA == 32'h0 && RESP == `RESP_ERROR)
		else $error("unmapped read not refused");
	a_timeout_ro: assert property (wr_at && idx == `IDX_TIMEOUT |=> RESP == `RESP_ERROR)
		else $error("timeout write not refused");
	a_status_ro: assert property (wr_at && idx == `IDX_STATUS |=> RESP == `RESP_ERROR)
		else $error("status write not refused");
	a_push_open: assert property (wr_at && idx == `IDX_PUSH |=> RESP == `RESP_OKAY)
		else $error("push write refused");
	a_ctrl_open: assert property (wr_at && idx == `IDX_CTRL |=> RESP == `RESP_OKAY)
		else $error("control write refused");
	a_quiet_resp: assert property (CE && !WR && !RD |=> RESP == `RESP_OKAY)
		else $error("error without host access");
	a_ctrl_bits: assert property (CE && RD && hit && idx == `IDX_CTRL |=> RDATA[31:2] == 30'h0)
		else $error("reserved control bits set");
	a_stop_gate: assert property (wr_at && idx == `IDX_CTRL && !WDATA[0] |=> !SEQ_CLK_EN)
		else $error("clock gate open after stop");
	a_result_dma: assert property (CE && RES_LOAD[0] |=> RES_DMA_REQ)
		else $error("no result request");
	c_start: cover property (wr_at && idx == `IDX_CTRL && WDATA[0]);
	c_error: cover property (RESP == `RESP_ERROR);
	c_stop: cover property ($fell(SEQ_CLK_EN));
endmodule
bind frontend_sequencer_reg_access fe_seq_checker i_fe_seq_checker (.CLOCK(CLOCK), .RST(RST), .CE(CE),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RESP(RESP), .RES_LOAD(RES_LOAD),
	.RES_DMA_REQ(RES_DMA_REQ), .SEQ_CLK_EN(SEQ_CLK_EN));

//--- tb/fe_host.sv
// Host bus master model for the register port
`timescale 1ns/1ps
module fe_host (
	// Clock
	input wire logic CLOCK,
	// Register port
	output logic [31:0] ADDR = 32'h0,
	output logic [31:0] WDATA = 32'h0,
	output logic WR = 1'b0,
	output logic RD = 1'b0,
	input wire logic [31:0] RDATA,
	input wire logic [1:0] RESP
);
	// One strobe cycle, answer taken in the next cycle
	task automatic access(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [1:0] r, output logic [31:0] q);
		@(posedge CLOCK);
		ADDR <= a;
		WDATA <= d;
		WR <= wr;
		RD <= !wr;
		@(posedge CLOCK);
		ADDR <= ~a;
		WDATA <= ~d;
		WR <= 1'b0;
		RD <= 1'b0;
		#1;
		r = RESP;
		q = RDATA;
	endtask
endmodule

//--- tb/frontend_sequencer_reg_access_test.sv
// Self-checking bench for the front-end sequencer
`timescale 1ns/1ps
`include "fe_seq_cfg.svh"
module frontend_sequencer_reg_access_test;
	typedef struct {logic wr; logic [5:0] idx; logic [31:0] d; logic [1:0] r; logic [31:0] q;} row_s;
	logic CLOCK = 1'b0;
	logic RST = 1'b1;
	logic CE = 1'b1;
	logic FE_TICK = 1'b0;
	logic [`NUM_RES-1:0] RES_LOAD = '0;
	logic [24:0] RES_DATA = 25'h0;
	wire [31:0] ADDR, WDATA, RDATA;
	wire [24:0] CFG_OUT;
	wire [1:0] RESP;
	wire WR, RD, IRQ, CMD_DMA_REQ, RES_DMA_REQ, SEQ_CLK_EN;
	int n_errors = 0;
	int compares = 0;
	logic [2:0] tick_q = 3'h0;
	logic [1:0] r;
	logic [31:0] q;
	row_s rows [8] = '{
		'{1, `IDX_CFG, 32'hFFABCDEF, `RESP_OKAY, 0},
		'{0, `IDX_CFG, 0, `RESP_OKAY, 32'h01ABCDEF},
		'{1, `IDX_TIMEOUT, 1, `RESP_ERROR, 0},
		'{1, `IDX_STATUS, 1, `RESP_ERROR, 0},
		'{0, 6'h3F, 0, `RESP_ERROR, 0},
		'{1, `IDX_RES0, 32'hFFFFFFFF, `RESP_OKAY, 0},
		'{0, `IDX_RES0, 0, `RESP_OKAY, 32'h01FFFFFF},
		'{0, `IDX_STATUS, 0, `RESP_OKAY, 32'h2}};
	// Config write, timeout 60, wait 30, protected push, stop
	logic [31:0] cmd_a [5] = '{32'h96000155, 32'h4000003C, 32'h0000001E, 32'h82000001, 32'h80000000};
	// Timeout 3 runs out during wait 40
	logic [31:0] cmd_b [3] = '{32'h40000003, 32'h00000028, 32'h80000000};
	frontend_sequencer_reg_access i_frontend_sequencer_reg_access (.CLOCK(CLOCK), .RST(RST), .CE(CE),
		.FE_TICK(FE_TICK), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RESP(RESP),
		.RES_LOAD(RES_LOAD), .RES_DATA(RES_DATA), .CFG_OUT(CFG_OUT), .IRQ(IRQ), .CMD_DMA_REQ(CMD_DMA_REQ),
		.RES_DMA_REQ(RES_DMA_REQ), .SEQ_CLK_EN(SEQ_CLK_EN));
	fe_host i_fe_host (.CLOCK(CLOCK), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RESP(RESP));
	always #5 CLOCK = ~CLOCK;
	// Front-end tick about every sixth bus cycle
	always @(posedge CLOCK)
	begin
		tick_q <= (tick_q == 3'h5) ? 3'h0 : tick_q + 3'h1;
		FE_TICK <= tick_q == 3'h5;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		if (n_errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] d);
		i_fe_host.access(wr, {`FE_BASE_HI, idx, 2'h0}, d, r, q);
	endtask
	// Read flags until all bits of m are set
	task automatic poll(input logic [31:0] m);
		int k = 0;
		bus(0, `IDX_FLAGS, 0);
		while ((q & m) !== m && k < 1000)
		begin
			bus(0, `IDX_FLAGS, 0);
			k++;
		end
		if (k == 1000)
		begin
			n_errors++;
			end_sim;
		end
	endtask
	initial
	begin
		repeat (20) @(posedge CLOCK);
		RST <= 1'b0;
		chk(32'(CFG_OUT), 0);
		chk(32'(SEQ_CLK_EN), 0);
		foreach (rows[i])
		begin
			bus(rows[i].wr, rows[i].idx, rows[i].d);
			chk(32'(r), 32'(rows[i].r));
			chk(q, rows[i].q);
		end
		foreach (cmd_a[i])
			bus(1, `IDX_PUSH, cmd_a[i]);
		bus(1, `IDX_CTRL, 1);
		chk(32'(r), `RESP_OKAY);
		chk(32'(CMD_DMA_REQ), 1);
		bus(1, `IDX_CFG, 0);
		chk(32'(r), `RESP_ERROR);
		bus(1, `IDX_RES0, 0);
		chk(32'(r), `RESP_ERROR);
		bus(1, `IDX_MASK, 1);
		chk(32'(r), `RESP_OKAY);
		poll(1);
		chk(32'(SEQ_CLK_EN), 0);
		chk(32'(CFG_OUT), 32'h155);
		chk(32'(IRQ), 1);
		bus(0, `IDX_STATUS, 0);
		chk(q, 32'h2);
		bus(0, `IDX_TIMEOUT, 0);
		chk(32'(q > 0 && q < 60), 1);
		poll(2);
		chk(q, 32'h3);
		bus(1, `IDX_FLAGS, 32'hF);
		bus(0, `IDX_FLAGS, 0);
		chk(q, 0);
		foreach (cmd_b[i])
			bus(1, `IDX_PUSH, cmd_b[i]);
		bus(1, `IDX_CTRL, 1);
		poll(1);
		chk(q, 32'h7);
		@(posedge CLOCK);
		RES_LOAD <= 1;
		RES_DATA <= 25'h0ABCDEF;
		@(posedge CLOCK);
		RES_LOAD <= 0;
		#1;
		chk(32'(RES_DMA_REQ), 1);
		bus(0, `IDX_RES0, 0);
		chk(q, 32'h0ABCDEF);
		chk(32'(RES_DMA_REQ), 0);
		// Write with the enable low must leave the configuration alone
		@(posedge CLOCK);
		CE <= 1'b0;
		bus(1, `IDX_CFG, 32'h00000005);
		CE <= 1'b1;
		bus(0, `IDX_CFG, 0);
		chk(q, 32'h00000155);
		end_sim;
	end
endmodule
